// File: core/lwcd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module lwcd_decoder
    import lwcd_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       wr_strobe,
    input  wire logic       data_not_cmd,
    input  wire logic [7:0] wr_byte,
    input  wire logic       data_rd_strobe,
    output logic [7:0]      column_addr,
    output logic [3:0]      page_addr,
    output logic [5:0]      start_line,
    output logic [5:0]      contrast_level,
    output logic [2:0]      reg_ratio,
    output logic            buffer_en,
    output logic            regulator_en,
    output logic            booster_en,
    output logic            seg_remap,
    output logic            bias_alt,
    output logic            entire_on,
    output logic            reverse_on,
    output logic            panel_on,
    output logic            com_reverse,
    output logic            rmw_active,
    output logic            power_save,
    output logic            ram_write,
    output logic [7:0]      ram_wdata
);
    // decoder state
    lwcd_state_t state_q, state_d;
    logic [7:0] col_q, col_d;            // live column address
    logic [7:0] col_save_q, col_save_d;  // column held at rmw entry
    logic [3:0] page_q, page_d;
    logic [5:0] start_q, start_d;
    logic [5:0] contrast_q, contrast_d;
    logic [2:0] ratio_q, ratio_d;
    logic [2:0] power_q, power_d;        // {booster, regulator, buffer}
    logic       seg_q, seg_d;
    logic       bias_q, bias_d;
    logic       entire_q, entire_d;
    logic       reverse_q, reverse_d;
    logic       panel_q, panel_d;
    logic       com_q, com_d;
    logic       rmw_q, rmw_d;
    logic       save_q, save_d;
    logic       last_off_q, last_off_d;  // previous command was display off
    logic       wr_q, wr_d;
    logic [7:0] wdata_q, wdata_d;
    logic       cmd_wr;
    logic       dat_wr;

    assign cmd_wr = wr_strobe && !data_not_cmd;
    assign dat_wr = wr_strobe && data_not_cmd;

    // next-state computation for all decoded registers
    always_comb
    begin
        state_d    = state_q;
        col_d      = col_q;
        col_save_d = col_save_q;
        page_d     = page_q;
        start_d    = start_q;
        contrast_d = contrast_q;
        ratio_d    = ratio_q;
        power_d    = power_q;
        seg_d      = seg_q;
        bias_d     = bias_q;
        entire_d   = entire_q;
        reverse_d  = reverse_q;
        panel_d    = panel_q;
        com_d      = com_q;
        rmw_d      = rmw_q;
        save_d     = save_q;
        last_off_d = last_off_q;
        wr_d       = dat_wr;
        wdata_d    = dat_wr ? wr_byte : wdata_q;
        // column advances on writes always, on reads only outside rmw
        if (dat_wr || (data_rd_strobe && !rmw_q))
        begin
            col_d = col_q + 8'h01;
        end
        if (cmd_wr)
        begin
            last_off_d = 1'b0;
            case (state_q)
                LWCD_WAIT_CONTRAST:
                begin
                    // second byte: upper two bits ignored
                    contrast_d = wr_byte[5:0];
                    state_d    = LWCD_IDLE;
                end
                default:
                begin
                    if (wr_byte[7:4] == CMD_COL_LO)
                        col_d = {col_q[7:4], wr_byte[3:0]};
                    else if (wr_byte[7:4] == CMD_COL_HI)
                        col_d = {wr_byte[3:0], col_q[3:0]};
                    else if (wr_byte[7:3] == CMD_REG_RATIO)
                        ratio_d = wr_byte[2:0];
                    else if (wr_byte[7:3] == CMD_POWER)
                        power_d = wr_byte[2:0];
                    else if (wr_byte[7:6] == CMD_START)
                        start_d = wr_byte[5:0];
                    else if (wr_byte == CMD_CONTRAST)
                        state_d = LWCD_WAIT_CONTRAST;
                    else if (wr_byte[7:1] == CMD_SEG_REMAP)
                        seg_d = wr_byte[0];
                    else if (wr_byte[7:1] == CMD_BIAS)
                        bias_d = wr_byte[0];
                    else if (wr_byte[7:1] == CMD_ENTIRE)
                    begin
                        entire_d = wr_byte[0];
                        // off followed by entire-on requests power save
                        save_d   = wr_byte[0] && last_off_q;
                    end
                    else if (wr_byte[7:1] == CMD_REVERSE)
                        reverse_d = wr_byte[0];
                    else if (wr_byte[7:1] == CMD_DISP_ON)
                    begin
                        panel_d    = wr_byte[0];
                        last_off_d = !wr_byte[0];
                        if (wr_byte[0])
                            save_d = 1'b0; // display on wakes the panel
                    end
                    else if (wr_byte[7:4] == CMD_PAGE)
                        page_d = wr_byte[3:0];
                    else if (wr_byte[7:4] == CMD_COM_DIR)
                        com_d = wr_byte[3];
                    else if (wr_byte == CMD_RMW_ENTER)
                    begin
                        rmw_d      = 1'b1;
                        col_save_d = col_q;
                    end
                    else if (wr_byte == CMD_RMW_EXIT)
                    begin
                        rmw_d = 1'b0;
                        col_d = col_save_q;
                    end
                    else if (wr_byte == CMD_SW_RESET)
                    begin
                        // status registers except col_save_q and wdata_q back to power-on values
                        col_d      = RST_COLUMN;
                        page_d     = RST_PAGE;
                        start_d    = RST_START;
                        contrast_d = RST_CONTRAST;
                        ratio_d    = RST_REG_RATIO;
                        power_d    = RST_POWER;
                        seg_d      = 1'b0;
                        bias_d     = 1'b0;
                        entire_d   = 1'b0;
                        reverse_d  = 1'b0;
                        panel_d    = 1'b0;
                        com_d      = 1'b0;
                        rmw_d      = 1'b0;
                        save_d     = 1'b0;
                    end
                end
            endcase
        end
    end

    // register stage only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_q    <= LWCD_IDLE;
            col_q      <= RST_COLUMN;
            col_save_q <= RST_COLUMN;
            page_q     <= RST_PAGE;
            start_q    <= RST_START;
            contrast_q <= RST_CONTRAST;
            ratio_q    <= RST_REG_RATIO;
            power_q    <= RST_POWER;
            seg_q      <= 1'b0;
            bias_q     <= 1'b0;
            entire_q   <= 1'b0;
            reverse_q  <= 1'b0;
            panel_q    <= 1'b0;
            com_q      <= 1'b0;
            rmw_q      <= 1'b0;
            save_q     <= 1'b0;
            last_off_q <= 1'b0;
            wr_q       <= 1'b0;
            wdata_q    <= 8'h00;
        end
        else
        begin
            state_q    <= state_d;
            col_q      <= col_d;
            col_save_q <= col_save_d;
            page_q     <= page_d;
            start_q    <= start_d;
            contrast_q <= contrast_d;
            ratio_q    <= ratio_d;
            power_q    <= power_d;
            seg_q      <= seg_d;
            bias_q     <= bias_d;
            entire_q   <= entire_d;
            reverse_q  <= reverse_d;
            panel_q    <= panel_d;
            com_q      <= com_d;
            rmw_q      <= rmw_d;
            save_q     <= save_d;
            last_off_q <= last_off_d;
            wr_q       <= wr_d;
            wdata_q    <= wdata_d;
        end
    end

    // outputs straight from flops
    assign column_addr    = col_q;
    assign page_addr      = page_q;
    assign start_line     = start_q;
    assign contrast_level = contrast_q;
    assign reg_ratio      = ratio_q;
    assign buffer_en      = power_q[0];
    assign regulator_en   = power_q[1];
    assign booster_en     = power_q[2];
    assign seg_remap      = seg_q;
    assign bias_alt       = bias_q;
    assign entire_on      = entire_q;
    assign reverse_on     = reverse_q;
    assign panel_on       = panel_q;
    assign com_reverse    = com_q;
    assign rmw_active     = rmw_q;
    assign power_save     = save_q;
    assign ram_write      = wr_q;
    assign ram_wdata      = wdata_q;

    // checks
    col_lo_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte[7:4] == CMD_COL_LO
        |=> col_q[3:0] == $past(wr_byte[3:0]))
        else $error("low column nibble not loaded");
    col_hi_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte[7:4] == CMD_COL_HI
        |=> col_q[7:4] == $past(wr_byte[3:0]))
        else $error("high column nibble not loaded");
    ratio_load_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte[7:3] == CMD_REG_RATIO
        |=> reg_ratio == $past(wr_byte[2:0]))
        else $error("regulator ratio not loaded");
    power_bits_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte[7:3] == CMD_POWER
        |=> {booster_en, regulator_en, buffer_en} == $past(wr_byte[2:0]))
        else $error("power enables wrong");
    contrast_two_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte == CMD_CONTRAST
        ##1 cmd_wr |=> contrast_level == $past(wr_byte[5:0]))
        else $error("contrast second byte not taken");
    data_ignored_a: assert property (@(posedge clock) disable iff (reset)
        dat_wr |=> panel_on == $past(panel_on) && page_addr == $past(page_addr))
        else $error("data byte decoded as command");
    rmw_restore_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte == CMD_RMW_EXIT
        |=> column_addr == $past(col_save_q) && !rmw_active)
        else $error("column not restored on rmw exit");
    rmw_hold_a: assert property (@(posedge clock) disable iff (reset)
        rmw_q && data_rd_strobe && !wr_strobe |=> col_q == $past(col_q))
        else $error("column moved on rmw read");
    save_seq_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte == 8'hae
        ##1 (cmd_wr && wr_byte == 8'ha5) |=> power_save)
        else $error("power save not recognised");
    sw_reset_a: assert property (@(posedge clock) disable iff (reset)
        cmd_wr && state_q == LWCD_IDLE && wr_byte == CMD_SW_RESET
        |=> contrast_level == RST_CONTRAST && reg_ratio == RST_REG_RATIO && !panel_on)
        else $error("software reset incomplete");
    cov_contrast: cover property (@(posedge clock) disable iff (reset)
        state_q == LWCD_WAIT_CONTRAST ##1 state_q == LWCD_IDLE);
    cov_save: cover property (@(posedge clock) disable iff (reset) $rose(power_save));
    cov_rmw: cover property (@(posedge clock) disable iff (reset) $fell(rmw_active));
endmodule
`default_nettype wire

// File: core/lwcd_pkg.sv
package lwcd_pkg;
    // command prefixes and full codes
    localparam logic [3:0] CMD_COL_LO    = 4'h0;
    localparam logic [3:0] CMD_COL_HI    = 4'h1;
    localparam logic [4:0] CMD_REG_RATIO = 5'h04;
    localparam logic [4:0] CMD_POWER     = 5'h05;
    localparam logic [1:0] CMD_START     = 2'h1;
    localparam logic [7:0] CMD_CONTRAST  = 8'h81;
    localparam logic [6:0] CMD_SEG_REMAP = 7'h50;
    localparam logic [6:0] CMD_BIAS      = 7'h51;
    localparam logic [6:0] CMD_ENTIRE    = 7'h52;
    localparam logic [6:0] CMD_REVERSE   = 7'h53;
    localparam logic [6:0] CMD_DISP_ON   = 7'h57;
    localparam logic [3:0] CMD_PAGE      = 4'hb;
    localparam logic [3:0] CMD_COM_DIR   = 4'hc;
    localparam logic [7:0] CMD_RMW_ENTER = 8'he0;
    localparam logic [7:0] CMD_SW_RESET  = 8'he2;
    localparam logic [7:0] CMD_RMW_EXIT  = 8'hee;
    // reset values
    localparam logic [7:0] RST_COLUMN    = 8'h00;
    localparam logic [2:0] RST_REG_RATIO = 3'h4;
    localparam logic [2:0] RST_POWER     = 3'h0;
    localparam logic [5:0] RST_START     = 6'h00;
    localparam logic [5:0] RST_CONTRAST  = 6'h20;
    localparam logic [3:0] RST_PAGE      = 4'h0;
    // decoder states
    typedef enum logic [0:0] {LWCD_IDLE, LWCD_WAIT_CONTRAST} lwcd_state_t;
endpackage

// File: verification/lwcd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the write port: single bytes with an idle cycle after, pairs back to back
module lwcd_host_model
(
    input  wire logic       clock,
    output logic            wr_strobe,
    output logic            data_not_cmd,
    output logic [7:0]      wr_byte,
    output logic            data_rd_strobe
);
    // idle levels from time zero
    initial
    begin
        wr_strobe      = 1'b0;
        data_not_cmd   = 1'b0;
        wr_byte        = 8'h00;
        data_rd_strobe = 1'b0;
    end

    // one write; lines are inverted after release so a stale byte never looks valid
    task automatic put(input logic dc, input logic [7:0] b);
        @(posedge clock);
        wr_strobe    <= 1'b1;
        data_not_cmd <= dc;
        wr_byte      <= b;
        @(posedge clock);
        wr_strobe    <= 1'b0;
        data_not_cmd <= ~dc;
        wr_byte      <= ~b;
        #1;
    endtask

    // command byte
    task automatic cmd(input logic [7:0] b);
        put(1'b0, b);
    endtask

    // display data byte
    task automatic dat(input logic [7:0] b);
        put(1'b1, b);
    endtask

    // two commands on consecutive edges: strobe stays up, only the byte changes
    task automatic pair(input logic [7:0] b0, input logic [7:0] b1);
        @(posedge clock);
        wr_strobe    <= 1'b1;
        data_not_cmd <= 1'b0;
        wr_byte      <= b0;
        @(posedge clock);
        wr_byte      <= b1;
        @(posedge clock);
        wr_strobe    <= 1'b0;
        data_not_cmd <= 1'b1;
        wr_byte      <= ~b1;
        #1;
    endtask

    // one display data read pulse
    task automatic rd();
        @(posedge clock);
        data_rd_strobe <= 1'b1;
        @(posedge clock);
        data_rd_strobe <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// File: verification/lwcd_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
module lwcd_decoder_test;
    import lwcd_pkg::*;
    // one table row: command byte, field to look at, expected field value
    typedef struct packed {logic [7:0] b; logic [3:0] id; logic [7:0] v;} lwcd_row_t;
    logic       clock;
    logic       reset;
    logic       wr_strobe, data_not_cmd, data_rd_strobe;
    logic [7:0] wr_byte, column_addr, ram_wdata;
    logic [3:0] page_addr;
    logic [5:0] start_line, contrast_level;
    logic [2:0] reg_ratio;
    logic       buffer_en, regulator_en, booster_en, seg_remap, bias_alt, entire_on;
    logic       reverse_on, panel_on, com_reverse, rmw_active, power_save, ram_write;
    logic [8:0] flg;
    int         fail_count = 0;
    int         cmp_count = 0;
    // settings rows, each builds on the state left by the rows above
    lwcd_row_t  rows [20] = '{
        '{8'h0a, 4'h0, 8'h0a},
        '{8'h15, 4'h0, 8'h5a},
        '{8'h27, 4'h4, 8'h07},
        '{8'h2b, 4'h5, 8'h03},
        '{8'h7f, 4'h2, 8'h3f},
        '{8'ha1, 4'h6, 8'h01},
        '{8'ha3, 4'h7, 8'h01},
        '{8'ha5, 4'h8, 8'h01},
        '{8'ha7, 4'h9, 8'h01},
        '{8'haf, 4'ha, 8'h01},
        '{8'hb8, 4'h1, 8'h08},
        '{8'hc8, 4'hb, 8'h01},
        '{8'ha0, 4'h6, 8'h00},
        '{8'ha2, 4'h7, 8'h00},
        '{8'ha4, 4'h8, 8'h00},
        '{8'ha6, 4'h9, 8'h00},
        '{8'hae, 4'ha, 8'h00},
        '{8'hc0, 4'hb, 8'h00},
        '{8'he3, 4'h0, 8'h5a},
        '{8'h2c, 4'h5, 8'h04}
    };

    assign flg = {ram_write, power_save, rmw_active, com_reverse, panel_on,
                  reverse_on, entire_on, bias_alt, seg_remap};

    lwcd_host_model host (.clock(clock), .wr_strobe(wr_strobe), .data_not_cmd(data_not_cmd),
                          .wr_byte(wr_byte), .data_rd_strobe(data_rd_strobe));

    lwcd_decoder dut (.clock(clock), .reset(reset), .wr_strobe(wr_strobe),
        .data_not_cmd(data_not_cmd), .wr_byte(wr_byte), .data_rd_strobe(data_rd_strobe),
        .column_addr(column_addr), .page_addr(page_addr), .start_line(start_line),
        .contrast_level(contrast_level), .reg_ratio(reg_ratio), .buffer_en(buffer_en),
        .regulator_en(regulator_en), .booster_en(booster_en), .seg_remap(seg_remap),
        .bias_alt(bias_alt), .entire_on(entire_on), .reverse_on(reverse_on),
        .panel_on(panel_on), .com_reverse(com_reverse), .rmw_active(rmw_active),
        .power_save(power_save), .ram_write(ram_write), .ram_wdata(ram_wdata));

    // 4 ns clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // field selector, widened to one byte so one compare serves all fields
    function automatic logic [7:0] fld(input logic [3:0] id);
        case (id)
            4'h0:    fld = column_addr;
            4'h1:    fld = {4'h0, page_addr};
            4'h2:    fld = {2'h0, start_line};
            4'h3:    fld = {2'h0, contrast_level};
            4'h4:    fld = {5'h00, reg_ratio};
            4'h5:    fld = {5'h00, booster_en, regulator_en, buffer_en};
            4'hf:    fld = ram_wdata;
            default: fld = {7'h00, flg[id - 4'h6]};
        endcase
    endfunction

    // compare and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every field except ram_wdata at its initial value, ram_write low
    task automatic check_init();
        logic [7:0] e;
        for (int i = 0; i < 15; i++)
        begin
            e = (i == 3) ? {2'h0, RST_CONTRAST} : (i == 4) ? {5'h00, RST_REG_RATIO} : 8'h00;
            chk(fld(i[3:0]), e);
        end
    endtask

    // single exit of the run
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog, well beyond the hundred or fewer cycles the tests need
    initial
    begin
        #20000;
        fail_count++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        reset = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1;
        check_init();
        foreach (rows[i])
        begin
            host.cmd(rows[i].b);
            chk(fld(rows[i].id), rows[i].v);
        end
        // data between contrast code and value does not break the pair
        host.cmd(8'h81);
        host.dat(8'h81);
        chk(fld(4'h0), 8'h5b);
        chk(fld(4'he), 8'h01);
        chk(fld(4'hf), 8'h81);
        host.cmd(8'hea);
        chk(fld(4'h3), 8'h2a);
        host.dat(8'hb3);
        chk(fld(4'h1), 8'h08);
        // column wraps at eight bits, write pulse lasts one cycle
        host.cmd(8'h0f);
        host.cmd(8'h1f);
        host.dat(8'h00);
        chk(fld(4'h0), 8'h00);
        @(posedge clock);
        #1;
        chk(fld(4'he), 8'h00);
        host.rd();
        chk(fld(4'h0), 8'h01);
        // read-modify-write holds column on reads, restores it on exit
        host.cmd(8'he0);
        chk(fld(4'hc), 8'h01);
        host.rd();
        chk(fld(4'h0), 8'h01);
        host.dat(8'h3c);
        chk(fld(4'h0), 8'h02);
        host.cmd(8'hee);
        chk(fld(4'h0), 8'h01);
        chk(fld(4'hc), 8'h00);
        // power save pair, cleared by display on
        host.pair(8'hae, 8'ha5);
        chk(fld(4'hd), 8'h01);
        host.cmd(8'haf);
        chk(fld(4'hd), 8'h00);
        host.pair(8'h81, 8'h3f);
        chk(fld(4'h3), 8'h3f);
        host.cmd(8'he2);
        check_init();
        // hardware reset in mid-run, with settings away from their initial values
        host.pair(8'h81, 8'h05);
        host.cmd(8'ha7);
        host.dat(8'h11);
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1;
        check_init();
        chk(fld(4'hf), 8'h00);
        // first command right after release is taken
        host.cmd(8'h2f);
        chk(fld(4'h5), 8'h07);
        give_verdict();
    end
endmodule
`default_nettype wire
